// file: hdl/nfbp_defs.svh
`ifndef NFBP_DEFS_SVH
`define NFBP_DEFS_SVH
// ==========================================
// software register byte offsets
`define NFBP_REG_CTRL 5'h00
`define NFBP_REG_FADDR 5'h04
`define NFBP_REG_PARAM 5'h08
`define NFBP_REG_PROT 5'h0C
`define NFBP_REG_BADDR 5'h10
`define NFBP_REG_STAT 5'h14
`define NFBP_REG_GETD 5'h18
// control fields
`define NFBP_CTRL_OP 2:0
`define NFBP_CTRL_GO 3
`define NFBP_CTRL_WP 8
`define NFBP_OP_LAST 3'h6
// ==========================================
// device commands and feature layout
`define NFBP_CMD_RESET 8'hFF
`define NFBP_CMD_SETF 8'hEF
`define NFBP_CMD_GETF 8'hEE
`define NFBP_CMD_READ 8'h00
`define NFBP_CMD_STAT 8'h70
`define NFBP_CMD_PROG 8'h80
`define NFBP_CMD_PCONF 8'h10
`define NFBP_PROT_C0 8'h4C
`define NFBP_PROT_C1 8'h03
`define NFBP_PROT_C2 8'h1D
`define NFBP_PROT_C3 8'h42
`define NFBP_FEAT_DRIVE 8'h80
`define NFBP_DRIVE_RST 2'h0
`define NFBP_ST_PROT 7
`define NFBP_ROW_PAGE 5:0
`define NFBP_ROW_BLK 15:6
`define NFBP_MAX_PASSES 3'h4
// ==========================================
// timing in ns and derived cycle counts
`define NFBP_CLK_NS 10
`define NFBP_T_CLS_NS 10
`define NFBP_T_WP_NS 10
`define NFBP_T_WH_NS 7
`define NFBP_T_RP_NS 25
`define NFBP_T_ADL_NS 70
`define NFBP_T_WB_NS 100
`define NFBP_CYC(ns) (((ns) + `NFBP_CLK_NS - 1) / `NFBP_CLK_NS)
`endif

// file: hdl/nfbp_pkg.sv
package nfbp_pkg;
   // ==========================================
   // operations, cycle kinds, sequence steps
   typedef enum logic [2:0] {OP_RESET, OP_SETF, OP_GETF, OP_PROT, OP_QUERY, OP_STAT, OP_PROG} nfbp_op_type;
   typedef enum logic [1:0] {K_CMD, K_ADDR, K_DOUT, K_DIN} nfbp_kind_type;
   typedef enum logic [2:0] {S_CMD, S_ADDR, S_DOUT, S_DIN, S_RB, S_ADL, S_END} nfbp_sk_type;
   typedef struct packed {
      nfbp_sk_type sk;
      logic [7:0] val;
   } nfbp_step_type;
   typedef enum {M_IDLE, M_RUN, M_CYC, M_WAIT} nfbp_mst_type;
   typedef enum {E_IDLE, E_SET, E_LOW, E_HIGH} nfbp_est_type;
endpackage : nfbp_pkg

// file: hdl/nfbp_cyc_if.sv
`timescale 1ns/1ps
interface nfbp_cyc_if;
   logic req;
   nfbp_pkg::nfbp_kind_type kind;
   logic [7:0] wbyte;
   logic done;
   logic [7:0] rbyte;
   modport ctl (output req, output kind, output wbyte, input done, input rbyte);
   modport eng (input req, input kind, input wbyte, output done, output rbyte);
endinterface : nfbp_cyc_if

// file: hdl/nfbp_cycle.sv
`timescale 1ns/1ps
`include "nfbp_defs.svh"
module nfbp_cycle (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // request side
   nfbp_cyc_if.eng cyc,
   // nand pins
   input wire logic [7:0] io_in,
   output logic [7:0] io_out,
   output logic io_oe_n,
   output logic cle,
   output logic ale,
   output logic we_n,
   output logic re_n
);
   nfbp_pkg::nfbp_est_type est_q;
   logic [2:0] cnt_q;
   logic din_q;
   logic done_q;
   logic [7:0] rbyte_q;
   logic [2:0] lim;
   logic tick_end;

   // ==========================================
   // phase length: setup, strobe low, strobe high
   assign lim = (est_q == nfbp_pkg::E_SET) ? 3'(`NFBP_CYC(`NFBP_T_CLS_NS)) :
                (est_q == nfbp_pkg::E_LOW) ? (din_q ? 3'(`NFBP_CYC(`NFBP_T_RP_NS)) : 3'(`NFBP_CYC(`NFBP_T_WP_NS))) :
                3'(`NFBP_CYC(`NFBP_T_WH_NS));
   assign tick_end = cnt_q == lim - 3'h1;
   assign cyc.done = done_q;
   assign cyc.rbyte = rbyte_q;

   always_ff @(posedge clk) begin
      if (rst || est_q == nfbp_pkg::E_IDLE || tick_end) begin
         cnt_q <= 3'h0;
      end else begin
         cnt_q <= cnt_q + 3'h1;
      end
   end

   // ==========================================
   // one bus cycle per request
   always_ff @(posedge clk) begin
      if (rst) begin
         est_q <= nfbp_pkg::E_IDLE;
         cle <= 1'b0;
         ale <= 1'b0;
         we_n <= 1'b1;
         re_n <= 1'b1;
         io_oe_n <= 1'b1;
         io_out <= 8'h00;
         din_q <= 1'b0;
         done_q <= 1'b0;
         rbyte_q <= 8'h00;
      end else begin
         done_q <= 1'b0;
         unique case (est_q)
            nfbp_pkg::E_IDLE: if (cyc.req) begin
               est_q <= nfbp_pkg::E_SET;
               cle <= cyc.kind == nfbp_pkg::K_CMD;
               ale <= cyc.kind == nfbp_pkg::K_ADDR;
               din_q <= cyc.kind == nfbp_pkg::K_DIN;
               io_oe_n <= cyc.kind == nfbp_pkg::K_DIN;
               io_out <= cyc.wbyte;
            end
            nfbp_pkg::E_SET: if (tick_end) begin
               est_q <= nfbp_pkg::E_LOW;
               we_n <= din_q;
               re_n <= !din_q;
            end
            nfbp_pkg::E_LOW: if (tick_end) begin
               est_q <= nfbp_pkg::E_HIGH;
               we_n <= 1'b1;
               re_n <= 1'b1;
               if (din_q) begin
                  rbyte_q <= io_in;
               end
            end
            nfbp_pkg::E_HIGH: if (tick_end) begin
               est_q <= nfbp_pkg::E_IDLE;
               done_q <= 1'b1;
               cle <= 1'b0;
               ale <= 1'b0;
               io_oe_n <= 1'b1;
            end
         endcase
      end
   end
endmodule : nfbp_cycle

// file: hdl/nfbp_order_guard.sv
`timescale 1ns/1ps
`include "nfbp_defs.svh"
module nfbp_order_guard (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // program request
   input wire logic [15:0] row,
   input wire logic commit,
   output logic ok
);
   logic [9:0] blk_q;
   logic [5:0] page_q;
   logic [2:0] passes_q;
   logic valid_q;
   wire [9:0] blk = row[`NFBP_ROW_BLK];
   wire [5:0] page = row[`NFBP_ROW_PAGE];
   wire same_blk = valid_q && blk == blk_q;
   wire same_page = same_blk && page == page_q;
   wire next_page = same_blk && {1'b0, page} == {1'b0, page_q} + 7'h01;

   // ==========================================
   // pages in rising order, few passes per page
   assign ok = same_page ? passes_q < `NFBP_MAX_PASSES : (next_page || (!same_blk && page == 6'h00));

   always_ff @(posedge clk) begin
      if (rst) begin
         valid_q <= 1'b0;
         blk_q <= 10'h000;
         page_q <= 6'h00;
         passes_q <= 3'h0;
      end else if (commit) begin
         valid_q <= 1'b1;
         blk_q <= blk;
         page_q <= page;
         passes_q <= same_page ? passes_q + 3'h1 : 3'h1;
      end
   end

   // ==========================================
   // checks
   default clocking gcb @(posedge clk); endclocking
   default disable iff (rst);
   chk_page_rising: assert property (commit && valid_q && blk == blk_q |-> page == page_q || page == page_q + 6'h01)
      else $error("page programmed out of order");
   chk_pass_limit: assert property (commit && same_page |=> passes_q <= `NFBP_MAX_PASSES && passes_q > 3'h1)
      else $error("too many passes on one page");
endmodule : nfbp_order_guard

// file: hdl/nfbp_ctrl.sv
`timescale 1ns/1ps
// Contract
// - set feature sends EFh, address, four bytes
// - no reset during set feature
// - read all four returned bytes first
// - protection is 4Ch,03h,1Dh,42h plus five bytes
// - query is 00h, four address bytes, 70h
// - program pages of a block in order
// - up to four partial passes per page
// - hold write protect low at power
`include "nfbp_defs.svh"
module nfbp_ctrl (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // software register port
   input wire logic [4:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [31:0] sw_rdata,
   // nand bus
   output logic nand_ce_n,
   output logic nand_cle,
   output logic nand_ale,
   output logic nand_we_n,
   output logic nand_re_n,
   output logic nand_wp_n,
   input wire logic [7:0] nand_io_in,
   output logic [7:0] nand_io_out,
   output logic nand_io_oe_n,
   input wire logic nand_rb_n
);
   nfbp_pkg::nfbp_mst_type mst_q;
   nfbp_pkg::nfbp_mst_type mst_d;
   nfbp_pkg::nfbp_op_type op_q;
   nfbp_pkg::nfbp_op_type op_new;
   nfbp_pkg::nfbp_step_type seq [0:15];
   nfbp_pkg::nfbp_step_type step;
   logic [3:0] idx_q;
   logic [3:0] idx_d;
   logic [3:0] wcnt_q;
   logic [3:0] wcnt_d;
   logic [7:0] feature_addr_byte_q;
   logic [31:0] param_q;
   logic [23:0] prot_q;
   logic [31:0] baddr_q;
   logic [31:0] get_q;
   logic [7:0] stat_q;
   logic [1:0] drive_q;
   logic wp_q;
   logic ce_n_q;
   logic refused_q;
   logic prot_on_q;
   logic blk_prot_q;
   logic guard_ok;
   logic [31:0] rd_val;
   logic [31:0] rdata_q;
   logic [3:0] n_cmd;
   logic [3:0] n_addr;
   logic [3:0] n_dout;
   logic [3:0] n_din;

   nfbp_cyc_if cyc ();

   // ==========================================
   // register port decode
   wire idle = mst_q == nfbp_pkg::M_IDLE;
   wire wr_ctrl = sw_wr && sw_addr == `NFBP_REG_CTRL;
   wire wr_data = sw_wr && idle;
   wire go = wr_ctrl && sw_wdata[`NFBP_CTRL_GO];
   wire [2:0] op_raw = sw_wdata[`NFBP_CTRL_OP];
   wire op_legal = op_raw <= `NFBP_OP_LAST;
   assign op_new = nfbp_pkg::nfbp_op_type'(op_raw);
   // one operation at a time, so no reset can cut into a set feature
   wire accept = go && idle && op_legal && (op_new != nfbp_pkg::OP_PROG || guard_ok);
   wire refuse = go && !accept;
   wire finish = mst_q == nfbp_pkg::M_RUN && step.sk == nfbp_pkg::S_END;
   wire din_done = cyc.done && step.sk == nfbp_pkg::S_DIN;

   always_ff @(posedge mclk) begin
      if (rst) begin
         feature_addr_byte_q <= 8'h00;
         param_q <= 32'h00000000;
         prot_q <= 24'h000000;
         baddr_q <= 32'h00000000;
      end else if (wr_data) begin
         if (sw_addr == `NFBP_REG_FADDR) begin
            feature_addr_byte_q <= sw_wdata[7:0];
         end
         if (sw_addr == `NFBP_REG_PARAM) begin
            param_q <= sw_wdata;
         end
         if (sw_addr == `NFBP_REG_PROT) begin
            prot_q <= sw_wdata[23:0];
         end
         if (sw_addr == `NFBP_REG_BADDR) begin
            baddr_q <= sw_wdata;
         end
      end
   end

   // write protect held low from reset until software lets go
   always_ff @(posedge mclk) begin
      if (rst) begin
         wp_q <= 1'b0;
      end else if (wr_ctrl) begin
         wp_q <= sw_wdata[`NFBP_CTRL_WP];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         refused_q <= 1'b0;
         op_q <= nfbp_pkg::OP_RESET;
      end else if (refuse) begin
         refused_q <= 1'b1;
      end else if (accept) begin
         refused_q <= 1'b0;
         op_q <= op_new;
      end
   end

   // ==========================================
   // command sequences, one table per operation
   wire [31:0] setf_bytes = (feature_addr_byte_q == `NFBP_FEAT_DRIVE) ?
                            {24'h000000, 6'h00, param_q[1:0]} : param_q;

   always_comb begin
      for (int k = 0; k < 16; k++) begin
         seq[k] = '{nfbp_pkg::S_END, 8'h00};
      end
      unique case (op_q)
         nfbp_pkg::OP_RESET: begin
            seq[0] = '{nfbp_pkg::S_CMD, `NFBP_CMD_RESET};
            seq[1] = '{nfbp_pkg::S_RB, 8'h00};
         end
         nfbp_pkg::OP_SETF: begin
            seq[0] = '{nfbp_pkg::S_CMD, `NFBP_CMD_SETF};
            seq[1] = '{nfbp_pkg::S_ADDR, feature_addr_byte_q};
            seq[2] = '{nfbp_pkg::S_ADL, 8'h00};
            for (int k = 0; k < 4; k++) begin
               seq[3 + k] = '{nfbp_pkg::S_DOUT, setf_bytes[8 * k +: 8]};
            end
            seq[7] = '{nfbp_pkg::S_RB, 8'h00};
         end
         nfbp_pkg::OP_GETF: begin
            seq[0] = '{nfbp_pkg::S_CMD, `NFBP_CMD_GETF};
            seq[1] = '{nfbp_pkg::S_ADDR, feature_addr_byte_q};
            seq[2] = '{nfbp_pkg::S_RB, 8'h00};
            for (int k = 0; k < 4; k++) begin
               seq[3 + k] = '{nfbp_pkg::S_DIN, 8'h00};
            end
         end
         nfbp_pkg::OP_PROT: begin
            seq[0] = '{nfbp_pkg::S_CMD, `NFBP_PROT_C0};
            seq[1] = '{nfbp_pkg::S_CMD, `NFBP_PROT_C1};
            seq[2] = '{nfbp_pkg::S_CMD, `NFBP_PROT_C2};
            seq[3] = '{nfbp_pkg::S_CMD, `NFBP_PROT_C3};
            seq[4] = '{nfbp_pkg::S_DOUT, 8'h00};
            seq[5] = '{nfbp_pkg::S_DOUT, 8'h00};
            seq[6] = '{nfbp_pkg::S_DOUT, prot_q[15:8]};
            seq[7] = '{nfbp_pkg::S_DOUT, prot_q[7:0]};
            seq[8] = '{nfbp_pkg::S_DOUT, prot_q[23:16]};
            seq[9] = '{nfbp_pkg::S_RB, 8'h00};
         end
         nfbp_pkg::OP_QUERY: begin
            seq[0] = '{nfbp_pkg::S_CMD, `NFBP_CMD_READ};
            for (int k = 0; k < 4; k++) begin
               seq[1 + k] = '{nfbp_pkg::S_ADDR, baddr_q[8 * k +: 8]};
            end
            seq[5] = '{nfbp_pkg::S_CMD, `NFBP_CMD_STAT};
            seq[6] = '{nfbp_pkg::S_DIN, 8'h00};
         end
         nfbp_pkg::OP_STAT: begin
            seq[0] = '{nfbp_pkg::S_CMD, `NFBP_CMD_STAT};
            seq[1] = '{nfbp_pkg::S_DIN, 8'h00};
         end
         nfbp_pkg::OP_PROG: begin
            seq[0] = '{nfbp_pkg::S_CMD, `NFBP_CMD_PROG};
            for (int k = 0; k < 4; k++) begin
               seq[1 + k] = '{nfbp_pkg::S_ADDR, baddr_q[8 * k +: 8]};
            end
            seq[5] = '{nfbp_pkg::S_ADL, 8'h00};
            // only the segment is loaded; the page buffer keeps all ones elsewhere
            for (int k = 0; k < 4; k++) begin
               seq[6 + k] = '{nfbp_pkg::S_DOUT, param_q[8 * k +: 8]};
            end
            seq[10] = '{nfbp_pkg::S_CMD, `NFBP_CMD_PCONF};
            seq[11] = '{nfbp_pkg::S_RB, 8'h00};
            seq[12] = '{nfbp_pkg::S_CMD, `NFBP_CMD_STAT};
            seq[13] = '{nfbp_pkg::S_DIN, 8'h00};
         end
      endcase
   end

   assign step = seq[idx_q];

   // ==========================================
   // sequencer
   always_comb begin
      mst_d = mst_q;
      idx_d = idx_q;
      wcnt_d = wcnt_q;
      unique case (mst_q)
         nfbp_pkg::M_IDLE: if (accept) begin
            mst_d = nfbp_pkg::M_RUN;
            idx_d = 4'h0;
         end
         nfbp_pkg::M_RUN: begin
            unique case (step.sk)
               nfbp_pkg::S_CMD, nfbp_pkg::S_ADDR, nfbp_pkg::S_DOUT, nfbp_pkg::S_DIN: mst_d = nfbp_pkg::M_CYC;
               nfbp_pkg::S_RB: begin
                  mst_d = nfbp_pkg::M_WAIT;
                  wcnt_d = 4'(`NFBP_CYC(`NFBP_T_WB_NS));
               end
               nfbp_pkg::S_ADL: begin
                  mst_d = nfbp_pkg::M_WAIT;
                  wcnt_d = 4'(`NFBP_CYC(`NFBP_T_ADL_NS));
               end
               nfbp_pkg::S_END: mst_d = nfbp_pkg::M_IDLE;
            endcase
         end
         nfbp_pkg::M_CYC: if (cyc.done) begin
            mst_d = nfbp_pkg::M_RUN;
            idx_d = idx_q + 4'h1;
         end
         nfbp_pkg::M_WAIT: begin
            if (wcnt_q != 4'h0) begin
               wcnt_d = wcnt_q - 4'h1;
            end else if (step.sk != nfbp_pkg::S_RB || nand_rb_n) begin
               mst_d = nfbp_pkg::M_RUN;
               idx_d = idx_q + 4'h1;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         mst_q <= nfbp_pkg::M_IDLE;
         idx_q <= 4'h0;
         wcnt_q <= 4'h0;
         ce_n_q <= 1'b1;
      end else begin
         mst_q <= mst_d;
         idx_q <= idx_d;
         wcnt_q <= wcnt_d;
         ce_n_q <= idle ? !accept : finish;
      end
   end

   // ==========================================
   // returned bytes and host-side shadows
   always_ff @(posedge mclk) begin
      if (rst) begin
         get_q <= 32'h00000000;
         stat_q <= 8'h00;
      end else if (din_done) begin
         if (op_q == nfbp_pkg::OP_GETF) begin
            get_q <= {cyc.rbyte, get_q[31:8]};
         end else begin
            stat_q <= cyc.rbyte;
         end
      end
   end

   // shadows are plain flops: loaded only by rst or when their op finishes, never by the reset op
   always_ff @(posedge mclk) begin
      if (rst) begin
         drive_q <= `NFBP_DRIVE_RST;
         prot_on_q <= 1'b0;
         blk_prot_q <= 1'b0;
      end else if (finish) begin
         if (op_q == nfbp_pkg::OP_SETF && feature_addr_byte_q == `NFBP_FEAT_DRIVE) begin
            drive_q <= param_q[1:0];
         end
         if (op_q == nfbp_pkg::OP_PROT) begin
            prot_on_q <= 1'b1;
         end
         if (op_q == nfbp_pkg::OP_QUERY || op_q == nfbp_pkg::OP_PROG) begin
            blk_prot_q <= !stat_q[`NFBP_ST_PROT];
         end
      end
   end

   // ==========================================
   // read port
   wire [31:0] stat_word = {14'h0000, drive_q, stat_q, 2'h0, wp_q, nand_rb_n, blk_prot_q, prot_on_q, refused_q, !idle};
   assign rd_val = (sw_addr == `NFBP_REG_CTRL) ? {23'h000000, wp_q, 5'h00, op_q} :
                   (sw_addr == `NFBP_REG_FADDR) ? {24'h000000, feature_addr_byte_q} :
                   (sw_addr == `NFBP_REG_PARAM) ? param_q :
                   (sw_addr == `NFBP_REG_PROT) ? {8'h00, prot_q} :
                   (sw_addr == `NFBP_REG_BADDR) ? baddr_q :
                   (sw_addr == `NFBP_REG_STAT) ? stat_word :
                   (sw_addr == `NFBP_REG_GETD) ? get_q : 32'h00000000;

   always_ff @(posedge mclk) begin
      if (rst || !sw_rd) begin
         rdata_q <= 32'h00000000;
      end else begin
         rdata_q <= rd_val;
      end
   end

   assign sw_rdata = rdata_q;

   // ==========================================
   // cycle engine, order guard, pins
   assign cyc.req = mst_q == nfbp_pkg::M_RUN && step.sk inside {nfbp_pkg::S_CMD, nfbp_pkg::S_ADDR,
                    nfbp_pkg::S_DOUT, nfbp_pkg::S_DIN};
   assign cyc.kind = (step.sk == nfbp_pkg::S_CMD) ? nfbp_pkg::K_CMD :
                     (step.sk == nfbp_pkg::S_ADDR) ? nfbp_pkg::K_ADDR :
                     (step.sk == nfbp_pkg::S_DOUT) ? nfbp_pkg::K_DOUT : nfbp_pkg::K_DIN;
   assign cyc.wbyte = step.val;

   nfbp_cycle u_cycle (
      .clk(mclk),
      .rst(rst),
      .cyc(cyc.eng),
      .io_in(nand_io_in),
      .io_out(nand_io_out),
      .io_oe_n(nand_io_oe_n),
      .cle(nand_cle),
      .ale(nand_ale),
      .we_n(nand_we_n),
      .re_n(nand_re_n)
   );

   nfbp_order_guard u_guard (
      .clk(mclk),
      .rst(rst),
      .row(baddr_q[31:16]),
      .commit(accept && op_new == nfbp_pkg::OP_PROG),
      .ok(guard_ok)
   );

   assign nand_ce_n = ce_n_q;
   assign nand_wp_n = wp_q;

   // ==========================================
   // checks: cycles issued per operation
   always_ff @(posedge mclk) begin
      if (rst || accept) begin
         n_cmd <= 4'h0;
         n_addr <= 4'h0;
         n_dout <= 4'h0;
         n_din <= 4'h0;
      end else if (cyc.done) begin
         n_cmd <= n_cmd + 4'(step.sk == nfbp_pkg::S_CMD);
         n_addr <= n_addr + 4'(step.sk == nfbp_pkg::S_ADDR);
         n_dout <= n_dout + 4'(step.sk == nfbp_pkg::S_DOUT);
         n_din <= n_din + 4'(step.sk == nfbp_pkg::S_DIN);
      end
   end

   default clocking mcb @(posedge mclk); endclocking
   default disable iff (rst);
   chk_setf_shape: assert property (finish && op_q == nfbp_pkg::OP_SETF |-> n_cmd == 4'h1 && n_addr == 4'h1 && n_dout == 4'h4)
      else $error("set feature sequence malformed");
   chk_no_reset_mid: assert property (cyc.req && cyc.kind == nfbp_pkg::K_CMD && cyc.wbyte == `NFBP_CMD_RESET |-> op_q == nfbp_pkg::OP_RESET && idx_q == 4'h0)
      else $error("reset command inside another sequence");
   chk_getf_four: assert property (finish && op_q == nfbp_pkg::OP_GETF |-> n_din == 4'h4 && n_cmd == 4'h1)
      else $error("get feature left bytes unread");
   chk_prot_shape: assert property (finish && op_q == nfbp_pkg::OP_PROT |-> n_cmd == 4'h4 && n_dout == 4'h5 && n_addr == 4'h0)
      else $error("protection sequence malformed");
   chk_query_order: assert property (cyc.req && cyc.kind == nfbp_pkg::K_CMD &&
      op_q == nfbp_pkg::OP_QUERY && cyc.wbyte == `NFBP_CMD_STAT |-> n_addr == 4'h4)
      else $error("status asked before full block address");
   chk_wp_release: assert property ($rose(nand_wp_n) |-> $past(wr_ctrl) && $past(sw_wdata[`NFBP_CTRL_WP]))
      else $error("write protect released without software");
   chk_ce_span: assert property (accept |=> !nand_ce_n [*2])
      else $error("chip enable not held for operation");
   chk_wait_ready: assert property (mst_q == nfbp_pkg::M_WAIT && step.sk == nfbp_pkg::S_RB && wcnt_q == 4'h0 && !nand_rb_n |=> mst_q == nfbp_pkg::M_WAIT)
      else $error("sequence ran on while device busy");
   cov_setf_done: cover property (finish && op_q == nfbp_pkg::OP_SETF);
   cov_getf_done: cover property (finish && op_q == nfbp_pkg::OP_GETF);
   cov_prot_done: cover property (finish && op_q == nfbp_pkg::OP_PROT);
   cov_refused: cover property (refuse && !idle);
endmodule : nfbp_ctrl

// file: tb/nfbp_dev_model.sv
`timescale 1ns/1ps
module nfbp_dev_model (
   // busy timing clock
   input wire logic clk,
   // nand pins
   input wire logic ce_n,
   input wire logic cle,
   input wire logic ale,
   input wire logic we_n,
   input wire logic re_n,
   input wire logic [7:0] dq,
   output logic [7:0] dout,
   output logic rb_oe_n
);
   // ==========================================
   // volatile state, power-up values
   logic [7:0] cmd = 8'h00, feature_addr_byte = 8'h00, rv = 8'h00, rng = 8'h00;
   logic [7:0] p80 [4] = '{default: 8'h00};
   logic [31:0] pc = 32'h0, ad = 32'h0;
   logic [15:0] hb = 16'h0;
   logic pon = 1'b0, st7 = 1'b1;
   int na = 0, nd = 0, ri = 0, bsy = 0;
   wire prot = pon && (rng == 8'h00 ? {6'h0, ad[31:22]} <= hb : {6'h0, ad[31:22]} >= hb);
   always @(posedge we_n) if (!ce_n) begin
      if (cle) begin
         cmd <= dq;
         pc <= {pc[23:0], dq};
         na <= 0;
         nd <= 0;
         ri <= 0;
         if (dq == 8'hFF || dq == 8'hEE) bsy <= 20;
         if (dq == 8'h10 || (dq == 8'h70 && cmd == 8'h00)) st7 <= !prot;
         if (dq == 8'h10) bsy <= prot ? 5 : 20;
      end else if (ale) begin
         if (na == 0) feature_addr_byte <= dq;
         ad[na*8+:8] <= dq;
         na <= na + 1;
      end else begin
         nd <= nd + 1;
         if (cmd == 8'hEF && feature_addr_byte == 8'h80) p80[nd] <= dq;
         if (cmd == 8'hEF && nd == 3) bsy <= 20;
         if (pc == 32'h4C031D42 && !pon) begin
            if (nd == 2) hb[15:8] <= dq;
            if (nd == 3) hb[7:0] <= dq;
            if (nd == 4) begin
               rng <= dq;
               pon <= 1'b1;
               bsy <= 20;
            end
         end
      end
   end
   // read data: features or status byte
   always @(negedge re_n) if (!ce_n) begin
      rv <= cmd == 8'hEE ? (feature_addr_byte == 8'h80 ? p80[ri] : 8'h00) : {st7, bsy == 0, 6'h0};
      ri <= ri + 1;
   end
   always @(posedge clk) if (bsy > 0) bsy <= bsy - 1;
   assign rb_oe_n = bsy == 0;
   // released bus shows inverse of last byte
   assign dout = re_n ? ~rv : rv;
endmodule : nfbp_dev_model

// file: tb/nfbp_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "nfbp_defs.svh"
module nfbp_ctrl_tb_top;
   logic mclk = 0, rst = 1, sw_wr = 0, sw_rd = 0, rd_p = 0;
   logic [4:0] sw_addr = 5'h00;
   logic [31:0] sw_wdata = 32'h0, sw_rdata, prm;
   logic ce_n, cle, ale, we_n, re_n, wp_n, oe_n, rb_oe_n;
   logic [7:0] io_o, m_o;
   logic [63:0] q[$];
   logic [63:0] ent;
   logic [1:0] drv;
   logic [9:0] blks [3] = '{10'h003, 10'h005, 10'h006};
   int error_cnt = 0, n_checks = 0, k;
   wire [7:0] dq = !oe_n ? io_o : m_o;
   nfbp_ctrl uut (.mclk(mclk), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
      .sw_rd(sw_rd), .sw_rdata(sw_rdata), .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale),
      .nand_we_n(we_n), .nand_re_n(re_n), .nand_wp_n(wp_n), .nand_io_in(dq), .nand_io_out(io_o),
      .nand_io_oe_n(oe_n), .nand_rb_n(rb_oe_n));
   nfbp_dev_model dev (.clk(mclk), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
      .dq(dq), .dout(m_o), .rb_oe_n(rb_oe_n));
   initial forever #5 mclk = ~mclk;
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task give_verdict;
      $display("errors %0d checks %0d", error_cnt, n_checks);
      if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   task wr(input logic [4:0] a, input logic [31:0] d);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge mclk);
      sw_wr <= 1'b0;
      @(posedge mclk);
   endtask : wr
   // read with masked expectation noted in the queue
   task rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      q.push_back({m, e});
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge mclk);
      sw_rd <= 1'b0;
      @(posedge mclk);
   endtask : rd
   task op(input logic [2:0] o);
      int i;
      wr(`NFBP_REG_CTRL, 32'h00000108 | {29'h0, o});
      for (i = 0; i < 3000; i++) begin
         @(posedge mclk);
         if (i > 2 && ce_n === 1'b1) break;
      end
      if (i == 3000) begin
         error_cnt++;
         give_verdict;
      end
   endtask : op
   always @(posedge mclk) begin
      rd_p <= sw_rd;
      if (rd_p) begin
         ent = q.pop_front();
         chk(sw_rdata & ent[63:32], ent[31:0]);
      end
   end
   initial begin
      void'($urandom(15917));
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd(`NFBP_REG_STAT, 32'h00030031, 32'h00000010);
      wr(`NFBP_REG_FADDR, 32'h80);
      op(3'h2);
      rd(`NFBP_REG_GETD, 32'hFFFFFFFF, 32'h0);
      drv = 2'($urandom_range(3, 1));
      prm = $urandom() & 32'hFFFFFFFC | {30'h0, drv};
      wr(`NFBP_REG_PARAM, prm);
      op(3'h1);
      op(3'h2);
      rd(`NFBP_REG_GETD, 32'hFFFFFFFF, {30'h0, drv});
      op(3'h0);
      op(3'h2);
      rd(`NFBP_REG_GETD, 32'hFFFFFFFF, {30'h0, drv});
      rd(`NFBP_REG_STAT, 32'h00030020, {14'h0, drv, 16'h0020});
      wr(`NFBP_REG_FADDR, 32'h81);
      op(3'h1);
      op(3'h2);
      rd(`NFBP_REG_GETD, 32'hFFFFFFFF, 32'h0);
      wr(`NFBP_REG_PROT, 32'h00000005);
      op(3'h3);
      for (k = 0; k < 3; k++) begin
         wr(`NFBP_REG_BADDR, {blks[k], 22'h0});
         op(3'h4);
         rd(`NFBP_REG_STAT, 32'h8, k < 2 ? 32'h8 : 32'h0);
      end
      op(3'h0);
      wr(`NFBP_REG_BADDR, {10'h003, 22'h0});
      op(3'h4);
      rd(`NFBP_REG_STAT, 32'h8, 32'h8);
      op(3'h6);
      rd(`NFBP_REG_STAT, 32'hA, 32'h8);
      wr(`NFBP_REG_BADDR, {10'h009, 6'h02, 16'h0});
      op(3'h6);
      rd(`NFBP_REG_STAT, 32'h2, 32'h2);
      wr(`NFBP_REG_BADDR, {10'h003, 22'h0});
      for (k = 0; k < 4; k++) begin
         op(3'h6);
         rd(`NFBP_REG_STAT, 32'h2, k < 3 ? 32'h0 : 32'h2);
      end
      op(3'h5);
      rd(`NFBP_REG_STAT, 32'h0000C000, 32'h00004000);
      rd(5'h1C, 32'hFFFFFFFF, 32'h0);
      give_verdict;
   end
endmodule : nfbp_ctrl_tb_top
